// *** verilog/irq_bank_pkg.sv ***
// Purpose: constants and types shared by the peripheral interrupt flag bank
// Assumes: 8-bit registers placed on a 32-bit classic wishbone bus
// Notes: one word per register, data in the low byte
package irq_bank_pkg;
    // register byte addresses
    localparam logic [4:0] ADR_FLAGS_ONE = 5'h00;
    localparam logic [4:0] ADR_FLAGS_TWO = 5'h04;
    localparam logic [4:0] ADR_CAN_FLAGS = 5'h08;
    localparam logic [4:0] ADR_ENABLES_ONE = 5'h0c;
    localparam logic [4:0] ADR_ENABLES_TWO = 5'h10;
    localparam logic [4:0] ADR_CAN_ENABLES = 5'h14;
    localparam logic [4:0] ADR_CONTROL = 5'h18;
    // number of registers with an address
    localparam int NUM_REGS = 7;
    // bit positions
    localparam int BIT_RX_SERIAL = 5;
    localparam int BIT_CAPCMP = 2;
    localparam int BIT_ENH_CAPCMP = 0;
    localparam int BIT_PARALLEL = 7;
    localparam int BIT_UNUSED_TWO = 5;
    localparam int BIT_TX2 = 4;
    localparam int BIT_TX1 = 3;
    localparam int BIT_TX0 = 2;
    localparam int BIT_RX1 = 1;
    localparam int BIT_RX0 = 0;
    localparam int BIT_CTL_GLOBAL = 0;
    localparam int BIT_CTL_PRIO = 1;
    // writable bit masks per register
    localparam logic [7:0] MASK_FLAGS_ONE = 8'hdf;
    localparam logic [7:0] MASK_FLAGS_TWO = 8'hdf;
    localparam logic [7:0] MASK_ENABLES_TWO = 8'hdf;
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_CAN_LEGACY_ONLY = 8'h0c;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // can operating modes
    localparam logic [1:0] CAN_MODE_LEGACY = 2'h0;
    localparam logic [1:0] CAN_MODE_ENH = 2'h1;
    localparam logic [1:0] CAN_MODE_FIFO = 2'h2;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } bus_state_type;
endpackage

// *** verilog/irq_bank_if.sv ***
// Purpose: register file carrier between the bus slave and the flag bank
// Assumes: single clock
// Notes: wr and rd are one-cycle strobes
`timescale 1ns/1ps
interface irq_bank_if;
    logic wr;
    logic rd;
    logic [4:0] adr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic hit;
    modport slave (output wr, output rd, output adr, output wdata, input rdata, input hit);
    modport bank (input wr, input rd, input adr, input wdata, output rdata, output hit);
endinterface

// *** verilog/irq_wb_slave.sv ***
// Purpose: classic wishbone slave that turns cycles into register strobes
// Assumes: one access per cycle pair, ack one cycle after stb
// Notes: unmapped addresses answer with err instead of ack
`timescale 1ns/1ps
module irq_wb_slave (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // wishbone
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [4:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // register side
    irq_bank_if.slave rf
);
    typedef struct packed {
        irq_bank_pkg::bus_state_type st;
        logic ack;
        logic err;
        logic [31:0] dat;
    } slave_state_type;
    slave_state_type s_r, s_nxt;
    logic go;

    // a request is taken only in idle, so each cycle gets exactly one answer
    assign go = cyc_i && stb_i && (s_r.st == irq_bank_pkg::BUS_IDLE);
    assign rf.adr = adr_i;
    assign rf.wdata = dat_i[7:0];
    assign rf.wr = go && we_i && sel_i[0] && rf.hit; // upper lanes hold nothing
    assign rf.rd = go && !we_i && rf.hit;

    // answer state machine
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ack = 1'b0;
        s_nxt.err = 1'b0;
        unique case (s_r.st)
            irq_bank_pkg::BUS_IDLE:
            begin
                if (go)
                begin
                    s_nxt.st = irq_bank_pkg::BUS_ACK;
                    s_nxt.ack = rf.hit;
                    s_nxt.err = !rf.hit;
                    s_nxt.dat = {24'h000000, rf.rdata};
                end
            end
            irq_bank_pkg::BUS_ACK:
                s_nxt.st = irq_bank_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            s_r <= '{st: irq_bank_pkg::BUS_IDLE, ack: 1'b0, err: 1'b0, dat: 32'h00000000};
        end
        else if (ce_i)
        begin
            s_r <= s_nxt;
        end
    end

    assign dat_o = s_r.dat;
    assign ack_o = s_r.ack;
    assign err_o = s_r.err;
endmodule

// *** verilog/irq_flag_bank.sv ***
// Purpose: sticky peripheral flags, enables and combined request output
// Assumes: peripheral events are one-cycle pulses on the system clock
// Notes: hardware set wins over a software clear in the same cycle
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// RULE1: timer-2 period match sets flags-one bit 1; software clears it.
// RULE2: timer-1 overflow sets flags-one bit 0; software clears it.
// RULE3: capture/compare flags set on capture or compare, never in pwm mode.
// RULE4: oscillator fail sets flags-two bit 7 once clock moved to internal oscillator.
// RULE5: comparator change sets flags-two bit 6; sticky until software clears.
// RULE6: nonvolatile write finish sets flags-two bit 4.
// RULE7: serial bus collision sets flags-two bit 3.
// RULE8: low-voltage trip sets flags-two bit 2.
// RULE9: timer-3 overflow sets flags-two bit 1.
// RULE10: bit 5 of flags-two and enables-two reads zero, ignores writes.
// RULE11: can flags 7,6,5 set on invalid message, wake activity, any error.
// RULE12: can bit 4 is buffer-2 done in mode 0, any tx done otherwise.
// RULE13: can bits 3,2 are buffer 1,0 done in mode 0, forced zero otherwise.
// RULE14: can bit 1 is buffer-1 receive in mode 0, any receive otherwise.
// RULE15: can bit 0 is buffer-0 receive, zero in mode 1, watermark in mode 2.
// RULE16: without priority levels, the global peripheral enable also gates requests.
// RULE17: each enable bit gates the flag at the same position.
// RULE18: in modes 1,2 enable bit 4 gates all tx buffer requests with per-buffer enables.
// RULE19: in modes 1,2 enable bit 1 gates all rx buffer requests with per-buffer enables.
// RULE20: can enable 0 gates buffer 0, reads zero in mode 1, watermark in mode 2.
// RULE21: all flags and enables reset to zero.
// RULE22: software keeps the parallel-port enable at zero on the small package.
// RULE23: flags set regardless of any enable.
// RULE24: priority on gives two request levels, off gives one level.
// RULE25: with priority off the global enable passes or blocks all peripheral requests.
// RULE26: serial receive flag is read-only, follows the receive buffer full state.
// RULE27: request asserted when any flag and its enable are both one.
module irq_flag_bank (
    // clock, enable and reset
    input wire logic MCLK_I,
    input wire logic CE_I,
    input wire logic RESET_N_I,
    // wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [4:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic WB_ERR_O,
    // peripheral event pulses, first flag register
    input wire logic [7:0] EVENTS_ONE_I,
    input wire logic SERIAL_RX_FULL_I,
    input wire logic CAPCMP_PWM_MODE_I,
    // peripheral event pulses, second flag register
    input wire logic [7:0] EVENTS_TWO_I,
    input wire logic ENH_CAPCMP_PWM_MODE_I,
    // can event pulses and mode
    input wire logic [7:0] CAN_EVENTS_I,
    input wire logic [1:0] CAN_MODE_I,
    input wire logic [7:0] CAN_TX_DONE_BUF_I,
    input wire logic [7:0] CAN_RX_NEW_BUF_I,
    input wire logic [7:0] PER_BUFFER_ENABLES_I,
    input wire logic [2:0] PER_TX_BUFFER_ENABLES_I,
    // requests toward the cpu
    output logic PERIPH_IRQ_O,
    output logic PERIPH_IRQ_HIGH_O,
    output logic PERIPH_IRQ_LOW_O,
    output logic SERIAL_RX_READ_O
);
    typedef struct packed {
        logic [7:0] flags_one;
        logic [7:0] peripheral_flags_two;
        logic [7:0] can_flags;
        logic [7:0] peripheral_enables_one;
        logic [7:0] peripheral_enables_two;
        logic [7:0] can_enables;
        logic periph_global_enable;
        logic priority_levels_on;
        logic irq;
        logic irq_high;
        logic irq_low;
        logic rx_read;
    } bank_state_type;
    bank_state_type s_r, s_nxt;

    irq_bank_if rf ();
    logic legacy;
    logic fifo_mode;
    logic [7:0] can_set;
    logic [7:0] can_mask;
    logic [7:0] ev_one;
    logic [7:0] ev_two;
    logic [7:0] pend_one;
    logic [7:0] pend_two;
    logic [7:0] pend_can;
    logic any_pend;
    logic [7:0] rd_mux;
    logic hit;

    irq_wb_slave bus (
        .clk_i(MCLK_I),
        .rst_n_i(RESET_N_I),
        .ce_i(CE_I),
        .cyc_i(WB_CYC_I),
        .stb_i(WB_STB_I),
        .we_i(WB_WE_I),
        .adr_i(WB_ADR_I),
        .sel_i(WB_SEL_I),
        .dat_i(WB_DAT_I),
        .dat_o(WB_DAT_O),
        .ack_o(WB_ACK_O),
        .err_o(WB_ERR_O),
        .rf(rf.slave)
    );

    // mode decode; mode 3 is reserved and treated like mode 2
    assign legacy = (CAN_MODE_I == irq_bank_pkg::CAN_MODE_LEGACY);
    assign fifo_mode = !legacy && (CAN_MODE_I != irq_bank_pkg::CAN_MODE_ENH);

    // capture/compare events masked in pwm mode
    always_comb
    begin
        ev_one = EVENTS_ONE_I;
        ev_one[irq_bank_pkg::BIT_CAPCMP] = EVENTS_ONE_I[irq_bank_pkg::BIT_CAPCMP]
            && !CAPCMP_PWM_MODE_I; // RULE3
        ev_two = EVENTS_TWO_I & irq_bank_pkg::MASK_FLAGS_TWO; // RULE10
        ev_two[irq_bank_pkg::BIT_ENH_CAPCMP] = EVENTS_TWO_I[irq_bank_pkg::BIT_ENH_CAPCMP]
            && !ENH_CAPCMP_PWM_MODE_I; // RULE3
    end

    // can set sources remapped per mode
    always_comb
    begin
        can_set = CAN_EVENTS_I; // RULE11
        can_mask = irq_bank_pkg::MASK_FULL;
        if (!legacy)
        begin
            can_set[irq_bank_pkg::BIT_TX2] = |CAN_TX_DONE_BUF_I; // RULE12
            can_set[irq_bank_pkg::BIT_RX1] = |CAN_RX_NEW_BUF_I; // RULE14
            can_mask = can_mask & ~irq_bank_pkg::MASK_CAN_LEGACY_ONLY; // RULE13
            if (!fifo_mode)
            begin
                can_mask[irq_bank_pkg::BIT_RX0] = 1'b0; // RULE15
            end
        end
    end

    // pending terms; group enables act with the per-buffer enables in modes 1,2
    always_comb
    begin
        pend_one = s_r.flags_one & s_r.peripheral_enables_one; // RULE17
        pend_two = s_r.peripheral_flags_two & s_r.peripheral_enables_two;
        pend_can = s_r.can_flags & s_r.can_enables;
        if (!legacy)
        begin
            pend_can[irq_bank_pkg::BIT_TX2] = s_r.can_flags[irq_bank_pkg::BIT_TX2]
                && s_r.can_enables[irq_bank_pkg::BIT_TX2]
                && ((|PER_TX_BUFFER_ENABLES_I) || (|PER_BUFFER_ENABLES_I)); // RULE18
            pend_can[irq_bank_pkg::BIT_RX1] = s_r.can_flags[irq_bank_pkg::BIT_RX1]
                && s_r.can_enables[irq_bank_pkg::BIT_RX1]
                && (|PER_BUFFER_ENABLES_I); // RULE19
        end
        any_pend = |{pend_one, pend_two, pend_can}; // RULE27
    end

    // register decode and read mux
    always_comb
    begin
        hit = 1'b1;
        rd_mux = irq_bank_pkg::RESET_BYTE;
        unique case (rf.adr)
            irq_bank_pkg::ADR_FLAGS_ONE: rd_mux = s_r.flags_one;
            irq_bank_pkg::ADR_FLAGS_TWO: rd_mux = s_r.peripheral_flags_two;
            irq_bank_pkg::ADR_CAN_FLAGS: rd_mux = s_r.can_flags;
            irq_bank_pkg::ADR_ENABLES_ONE: rd_mux = s_r.peripheral_enables_one;
            irq_bank_pkg::ADR_ENABLES_TWO: rd_mux = s_r.peripheral_enables_two;
            irq_bank_pkg::ADR_CAN_ENABLES: rd_mux = s_r.can_enables;
            irq_bank_pkg::ADR_CONTROL:
            begin
                rd_mux[irq_bank_pkg::BIT_CTL_GLOBAL] = s_r.periph_global_enable;
                rd_mux[irq_bank_pkg::BIT_CTL_PRIO] = s_r.priority_levels_on;
            end
            default: hit = 1'b0;
        endcase
    end
    assign rf.rdata = rd_mux;
    assign rf.hit = hit;

    // next state: software write first, hardware set or'ed on top so set wins
    always_comb
    begin
        s_nxt = s_r;
        if (rf.wr)
        begin
            unique case (rf.adr)
                irq_bank_pkg::ADR_FLAGS_ONE:
                    s_nxt.flags_one = rf.wdata & irq_bank_pkg::MASK_FLAGS_ONE; // RULE26
                irq_bank_pkg::ADR_FLAGS_TWO:
                    s_nxt.peripheral_flags_two = rf.wdata & irq_bank_pkg::MASK_FLAGS_TWO; // RULE10
                irq_bank_pkg::ADR_CAN_FLAGS:
                    s_nxt.can_flags = rf.wdata;
                irq_bank_pkg::ADR_ENABLES_ONE:
                    s_nxt.peripheral_enables_one = rf.wdata; // RULE22
                irq_bank_pkg::ADR_ENABLES_TWO:
                    s_nxt.peripheral_enables_two = rf.wdata & irq_bank_pkg::MASK_ENABLES_TWO; // RULE10
                irq_bank_pkg::ADR_CAN_ENABLES:
                    s_nxt.can_enables = rf.wdata;
                irq_bank_pkg::ADR_CONTROL:
                begin
                    s_nxt.periph_global_enable = rf.wdata[irq_bank_pkg::BIT_CTL_GLOBAL];
                    s_nxt.priority_levels_on = rf.wdata[irq_bank_pkg::BIT_CTL_PRIO];
                end
                default: s_nxt = s_r;
            endcase
        end
        // flags set regardless of enables
        s_nxt.flags_one = s_nxt.flags_one | (ev_one & irq_bank_pkg::MASK_FLAGS_ONE); // RULE1 RULE2 RULE23
        s_nxt.flags_one[irq_bank_pkg::BIT_RX_SERIAL] = SERIAL_RX_FULL_I; // RULE26
        s_nxt.peripheral_flags_two = s_nxt.peripheral_flags_two | ev_two; // RULE4 RULE5 RULE6 RULE7 RULE8 RULE9
        s_nxt.can_flags = (s_nxt.can_flags | can_set) & can_mask; // RULE13 RULE15
        s_nxt.can_enables = s_nxt.can_enables & can_mask; // RULE13 RULE20
        // single level: global enable gates all; two levels: global enable gates only the low level
        s_nxt.irq = any_pend && (s_r.priority_levels_on || s_r.periph_global_enable); // RULE16 RULE25
        s_nxt.irq_high = any_pend && s_r.priority_levels_on; // RULE24
        s_nxt.irq_low = any_pend && s_r.priority_levels_on && s_r.periph_global_enable; // RULE24
        // a read of the first flag register stands in for the receive buffer read
        s_nxt.rx_read = rf.rd && (rf.adr == irq_bank_pkg::ADR_FLAGS_ONE);
    end

    // all state registered; cleared on reset, frozen while clock enable low
    always_ff @(posedge MCLK_I)
    begin
        if (!RESET_N_I)
        begin
            s_r <= '0; // RULE21
        end
        else if (CE_I)
        begin
            s_r <= s_nxt;
        end
    end

    assign PERIPH_IRQ_O = s_r.irq;
    assign PERIPH_IRQ_HIGH_O = s_r.irq_high;
    assign PERIPH_IRQ_LOW_O = s_r.irq_low;
    assign SERIAL_RX_READ_O = s_r.rx_read;
endmodule

// *** testbench/periph_model.sv ***
// Purpose: peripheral side firing event pulses into the flag bank
// Assumes: events are one-cycle pulses launched just after a clock edge
// Notes: the serial receiver empties when the bank reports a buffer read
`timescale 1ns/1ps
module periph_model (
    // clock and read strobe
    input wire logic clk_i,
    input wire logic rx_read_i,
    // event pulses and receive level
    output logic [7:0] ev_one_o,
    output logic [7:0] ev_two_o,
    output logic [7:0] ev_can_o,
    output logic [7:0] tx_done_o,
    output logic [7:0] rx_new_o,
    output logic rx_full_o
);
    // quiet until told otherwise
    initial
    begin
        {ev_one_o, ev_two_o, ev_can_o, tx_done_o, rx_new_o} = 40'h0;
        rx_full_o = 1'b0;
    end
    // one pulse on one group; groups never overlap in time
    task automatic fire(input int grp, input logic [7:0] bits);
        @(posedge clk_i);
        case (grp)
            0: ev_one_o <= bits;
            1: ev_two_o <= bits;
            2: ev_can_o <= bits;
            3: tx_done_o <= bits;
            default: rx_new_o <= bits;
        endcase
        @(posedge clk_i);
        {ev_one_o, ev_two_o, ev_can_o, tx_done_o, rx_new_o} <= 40'h0;
    endtask
    // a byte lands in the receive buffer
    task automatic receive();
        @(posedge clk_i);
        rx_full_o <= 1'b1;
    endtask
    // buffer read by software empties it
    always @(posedge clk_i)
    begin
        if (rx_read_i)
            rx_full_o <= 1'b0;
    end
endmodule

// *** testbench/irq_bank_asserts.sv ***
// Purpose: bus and request checks on the flag bank ports
// Assumes: one clock, synchronous active-low reset
// Notes: attached by bind below
`timescale 1ns/1ps
module irq_bank_asserts (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic CE_I,
    input wire logic RESET_N_I,
    // bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [4:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic WB_ERR_O,
    // mode and requests
    input wire logic [1:0] CAN_MODE_I,
    input wire logic PERIPH_IRQ_O,
    input wire logic PERIPH_IRQ_HIGH_O,
    input wire logic PERIPH_IRQ_LOW_O,
    input wire logic SERIAL_RX_READ_O
);
    logic rd0_req;
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RESET_N_I);
    // read request of the first flag register
    assign rd0_req = WB_CYC_I && WB_STB_I && !WB_WE_I && WB_ADR_I == 5'h00;
    // request taken while the slave is idle
    sequence s_take;
        WB_CYC_I && WB_STB_I && CE_I && !WB_ACK_O && !WB_ERR_O;
    endsequence
    // answer to a read of the can flags or can enables
    sequence s_read_can;
        WB_ACK_O && $past(!WB_WE_I) && ($past(WB_ADR_I) == 5'h08 || $past(WB_ADR_I) == 5'h14);
    endsequence
    // answer to a read of the unused bit registers
    sequence s_read_two;
        WB_ACK_O && $past(!WB_WE_I) && ($past(WB_ADR_I) == 5'h04 || $past(WB_ADR_I) == 5'h10);
    endsequence
    a_take_answer: assert property (s_take |=> (WB_ACK_O || WB_ERR_O))
        else $error("request not answered next cycle");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_err_unmapped: assert property (WB_ERR_O |-> $past(WB_ADR_I) > 5'h18
        || $past(WB_ADR_I[1:0]) != 2'h0) else $error("error on a mapped address");
    a_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
        else $error("upper read bytes not zero");
    a_unused_zero: assert property (s_read_two |-> !WB_DAT_O[5])
        else $error("unused bit reads one");
    a_can_forced: assert property (s_read_can ##0 $past(CAN_MODE_I) != 2'h0
        && CAN_MODE_I != 2'h0 |-> WB_DAT_O[3:2] == 2'h0) else $error("forced bits set");
    a_mode1_bit0: assert property (s_read_can ##0 $past(CAN_MODE_I) == 2'h1
        && CAN_MODE_I == 2'h1 |-> !WB_DAT_O[0]) else $error("bit 0 set in mode 1");
    a_rx_strobe: assert property (SERIAL_RX_READ_O |-> $past(rd0_req)
        || $past(rd0_req, 2)) else $error("receive read strobe without read");
    a_rx_single: assert property (SERIAL_RX_READ_O |=> !SERIAL_RX_READ_O)
        else $error("receive read strobe too long");
    a_level_nest: assert property (PERIPH_IRQ_LOW_O |-> PERIPH_IRQ_HIGH_O && PERIPH_IRQ_O)
        else $error("low level request without high and main");
    a_reset_quiet: assert property (disable iff (1'b0) !RESET_N_I |=>
        !PERIPH_IRQ_O && !WB_ACK_O) else $error("outputs active in reset");
endmodule
bind irq_flag_bank irq_bank_asserts irq_bank_asserts_i (.MCLK_I(MCLK_I), .CE_I(CE_I),
    .RESET_N_I(RESET_N_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .WB_ERR_O(WB_ERR_O),
    .CAN_MODE_I(CAN_MODE_I), .PERIPH_IRQ_O(PERIPH_IRQ_O), .PERIPH_IRQ_HIGH_O(PERIPH_IRQ_HIGH_O),
    .PERIPH_IRQ_LOW_O(PERIPH_IRQ_LOW_O), .SERIAL_RX_READ_O(SERIAL_RX_READ_O));

// *** testbench/test_irq_flag_bank.sv ***
// Purpose: register and request tests of the flag bank over wishbone
// Assumes: 25 MHz clock, reset held 16 cycles
// Notes: sel is held constant; both pwm modes share one bench signal
`timescale 1ns/1ps
module test_irq_flag_bank;
    logic clk, rst_n, cyc, stb, we, ack, err, pwm, got_err, ce;
    logic [4:0] adr;
    logic [31:0] wdat, rdat, got;
    logic [1:0] mode;
    logic [7:0] buf_en, ev_one, ev_two, ev_can, tx_done, rx_new;
    logic [2:0] tx_en;
    logic rx_full, irq, irq_hi, irq_lo, rx_read;
    int fails, total_checks;
    irq_flag_bank irq_flag_bank_i (.MCLK_I(clk), .CE_I(ce), .RESET_N_I(rst_n),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .WB_ERR_O(err),
        .EVENTS_ONE_I(ev_one), .SERIAL_RX_FULL_I(rx_full), .CAPCMP_PWM_MODE_I(pwm),
        .EVENTS_TWO_I(ev_two), .ENH_CAPCMP_PWM_MODE_I(pwm), .CAN_EVENTS_I(ev_can),
        .CAN_MODE_I(mode), .CAN_TX_DONE_BUF_I(tx_done), .CAN_RX_NEW_BUF_I(rx_new),
        .PER_BUFFER_ENABLES_I(buf_en), .PER_TX_BUFFER_ENABLES_I(tx_en),
        .PERIPH_IRQ_O(irq), .PERIPH_IRQ_HIGH_O(irq_hi), .PERIPH_IRQ_LOW_O(irq_lo),
        .SERIAL_RX_READ_O(rx_read));
    periph_model periph_model_i (.clk_i(clk), .rx_read_i(rx_read), .ev_one_o(ev_one),
        .ev_two_o(ev_two), .ev_can_o(ev_can), .tx_done_o(tx_done), .rx_new_o(rx_new),
        .rx_full_o(rx_full));
    // free running clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // seen against expected, counted either way
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        if (fails == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // one classic cycle, held until ack or err is sampled
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && err !== 1'b1 && n < 50);
        got = rdat;
        got_err = err;
        check(32'(n < 50), 32'h1);
        {cyc, stb, we} <= 3'b000;
        @(posedge clk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        check(got, {24'h0, exp});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    // watchdog: far beyond the few hundred cycles the tests need
    initial
    begin
        idle(20000);
        fails++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        report_and_stop();
    end
    initial
    begin
        {rst_n, cyc, stb, we, adr, wdat, pwm, mode, buf_en, tx_en} = '0;
        ce = 1'b1;
        fails = 0;
        total_checks = 0;
        idle(16);
        rst_n <= 1'b1;
        for (int a = 0; a < 7; a++)
            rd(5'(a * 4), 8'h00);
        bus(1'b0, 5'h1c, 8'h00);
        check(32'(got_err), 32'h1);
        bus(1'b1, 5'h0c, 8'h7f);
        rd(5'h0c, 8'h7f);
        periph_model_i.fire(1, 8'hff);
        rd(5'h04, 8'hdf);
        bus(1'b1, 5'h04, 8'h00);
        rd(5'h04, 8'h00);
        bus(1'b1, 5'h10, 8'hff);
        rd(5'h10, 8'hdf);
        pwm <= 1'b1;
        periph_model_i.fire(0, 8'h07);
        periph_model_i.fire(1, 8'h01);
        rd(5'h00, 8'h03);
        rd(5'h04, 8'h00);
        pwm <= 1'b0;
        periph_model_i.fire(1, 8'h01);
        rd(5'h04, 8'h01);
        periph_model_i.fire(0, 8'h04);
        rd(5'h00, 8'h07);
        bus(1'b1, 5'h00, 8'h00);
        periph_model_i.receive();
        idle(2);
        rd(5'h00, 8'h20);
        bus(1'b1, 5'h00, 8'h20);
        idle(3);
        rd(5'h00, 8'h00);
        // request gating: enable, global and priority controls
        bus(1'b1, 5'h0c, 8'h00);
        periph_model_i.fire(1, 8'h02);
        bus(1'b1, 5'h10, 8'h02);
        idle(2);
        check(32'(irq), 32'h0);
        for (int c = 1; c < 4; c++)
        begin
            bus(1'b1, 5'h18, 8'(c));
            idle(2);
            check(32'({irq, irq_hi, irq_lo}), 32'({1'b1, c[1], c[1] & c[0]}));
        end
        bus(1'b1, 5'h10, 8'h00);
        idle(2);
        check(32'(irq), 32'h0);
        bus(1'b1, 5'h18, 8'h01);
        // can modes 0 to 2, flags and enables
        for (int m = 0; m < 3; m++)
        begin
            mode <= 2'(m);
            idle(2);
            bus(1'b1, 5'h08, 8'h00);
            bus(1'b1, 5'h14, 8'hff);
            periph_model_i.fire(2, m == 0 ? 8'hff : 8'hed);
            periph_model_i.fire(3, 8'h01);
            periph_model_i.fire(4, 8'h01);
            rd(5'h08, m == 0 ? 8'hff : (m == 1 ? 8'hf2 : 8'hf3));
            rd(5'h14, m == 0 ? 8'hff : (m == 1 ? 8'hf2 : 8'hf3));
        end
        // group enables in mode 2 need per-buffer enables
        bus(1'b1, 5'h08, 8'h00);
        bus(1'b1, 5'h14, 8'h02);
        periph_model_i.fire(4, 8'h01);
        idle(2);
        check(32'(irq), 32'h0);
        buf_en <= 8'h01;
        idle(2);
        check(32'(irq), 32'h1);
        buf_en <= 8'h00;
        bus(1'b1, 5'h08, 8'h00);
        bus(1'b1, 5'h14, 8'h10);
        periph_model_i.fire(3, 8'h01);
        idle(2);
        check(32'(irq), 32'h0);
        {buf_en, tx_en} <= 11'h7ff;
        idle(2);
        check(32'(irq), 32'h1);
        // clock enable low freezes the request although its cause is gone
        ce <= 1'b0;
        {buf_en, tx_en} <= 11'h000;
        idle(2);
        check(32'(irq), 32'h1);
        ce <= 1'b1;
        idle(2);
        check(32'(irq), 32'h0);
        report_and_stop();
    end
endmodule
